// File: verilog/asd_pkg.sv
// Constants for the subtract, compare, adjust, multiply and divide decoder.
// Assumes opcode bytes arrive one per handshake from a fetch queue on CLOCK.
package asd_pkg;

   // ----------------------------------------------------------------------
   // Opcode patterns and masks
   // ----------------------------------------------------------------------
   localparam logic [7:0] MASK_W          = 8'hfe; // Ignore size bit
   localparam logic [7:0] MASK_DW         = 8'hfc; // Ignore target and size bits
   localparam logic [7:0] MASK_S          = 8'hfd; // Ignore extend bit
   localparam logic [7:0] OPC_SUBI_ACC    = 8'h2c;
   localparam logic [7:0] OPC_MWCI_RM     = 8'h18;
   localparam logic [7:0] OPC_MWCI_ACC    = 8'h1c;
   localparam logic [7:0] OPC_GRP_IMM     = 8'h80;
   localparam logic [7:0] OPC_CMPI_ACC    = 8'h3c;
   localparam logic [7:0] OPC_ASCII_ADD   = 8'h37;
   localparam logic [7:0] OPC_BCD_ADD     = 8'h27;
   localparam logic [7:0] OPC_ASCII_SUB   = 8'h3f;
   localparam logic [7:0] OPC_BCD_SUB     = 8'h2f;
   localparam logic [7:0] OPC_GRP_UNARY   = 8'hf6;
   localparam logic [7:0] OPC_MULI        = 8'h69;

   // ----------------------------------------------------------------------
   // Addressing byte fields
   // ----------------------------------------------------------------------
   localparam int         MOD_POS  = 6;
   localparam int         REG_POS  = 3;
   localparam int         RM_POS   = 0;
   localparam logic [1:0] MOD_REG  = 2'b11;
   localparam logic [2:0] REG_CMP  = 3'b111;
   localparam logic [2:0] REG_MULU = 3'b100;
   localparam logic [2:0] REG_MULS = 3'b101;
   localparam logic [2:0] REG_DIVU = 3'b110;

   // ----------------------------------------------------------------------
   // Execution clock counts
   // ----------------------------------------------------------------------
   localparam int         CNT_W       = 5;
   localparam logic [4:0] T_SUBI_ACC  = 5'h03;
   localparam logic [4:0] T_MWCI_REG  = 5'h02;
   localparam logic [4:0] T_MWCI_MEM  = 5'h07;
   localparam logic [4:0] T_MWCI_ACC  = 5'h03;
   localparam logic [4:0] T_CMPI_REG  = 5'h03;
   localparam logic [4:0] T_CMPI_MEM  = 5'h06;
   localparam logic [4:0] T_CMPI_ACC  = 5'h03;
   localparam logic [4:0] T_ADJUST    = 5'h03;
   localparam logic [4:0] T_MULU_RB   = 5'h0d;
   localparam logic [4:0] T_MULU_RW   = 5'h15;
   localparam logic [4:0] T_MULU_MB   = 5'h10;
   localparam logic [4:0] T_MULU_MW   = 5'h18;
   localparam logic [4:0] T_MULS_RB   = 5'h0d;
   localparam logic [4:0] T_MULS_RW   = 5'h15;
   localparam logic [4:0] T_MULS_MB   = 5'h10;
   localparam logic [4:0] T_MULS_MW   = 5'h18;
   localparam logic [4:0] T_MULI_REG  = 5'h15;
   localparam logic [4:0] T_MULI_MEM  = 5'h18;
   localparam logic [4:0] T_DIVU_RB   = 5'h0e;
   localparam logic [4:0] T_DIVU_RW   = 5'h16;
   localparam logic [4:0] T_DIVU_MB   = 5'h11;
   localparam logic [4:0] T_DIVU_MW   = 5'h19;

   // ----------------------------------------------------------------------
   // Decoded operation kinds
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NONE,
      OP_MINUS_IMM_ACC,
      OP_MINUS_WITH_CARRY_IN_RM,
      OP_MINUS_WITH_CARRY_IN_ACC,
      OP_COMPARE_OP_RM,
      OP_COMPARE_OP_ACC,
      OP_ASCII_ADD_FIX,
      OP_BCD_ADD_FIX,
      OP_ASCII_SUB_FIX,
      OP_BCD_SUB_FIX,
      OP_PRODUCT_UNSIGNED,
      OP_PRODUCT_SIGNED,
      OP_PRODUCT_SIGNED_IMMEDIATE,
      OP_QUOTIENT_UNSIGNED
   } asd_op_t;

endpackage : asd_pkg

// File: verilog/asd_cycle_timer.sv
// Down counter that holds busy for exactly the loaded number of clocks.
// Assumes start is a one-cycle pulse and count is nonzero.
`timescale 1ns/10ps
module asd_cycle_timer
   import asd_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         start,
   input  wire logic [W-1:0] count,
   output logic              busy,
   output logic              done
);

   typedef struct packed {
      logic [W-1:0] cnt;
   } asd_tmr_t;

   asd_tmr_t q;
   asd_tmr_t d;

   // --------------------------------------------------------------------
   // Count down; busy on the cycle after start
   // --------------------------------------------------------------------
   always_comb begin
      d = q;
      if (start) begin
         d.cnt = count;
      end else if (q.cnt != '0) begin
         d.cnt = q.cnt - W'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Done marks the last busy clock so the decoder frees up without a gap
   assign busy = (q.cnt != '0);
   assign done = (q.cnt == W'(1));

endmodule : asd_cycle_timer

// File: verilog/asd_decode.sv
// Opcode decoder and clock timing for the subtract, compare, adjust,
// multiply and divide forms. Takes bytes from the fetch queue one per
// handshake; displacement bytes are assumed stripped by the fetch path.
`timescale 1ns/10ps

// Function
// - 0010110w is subtract immediate from accumulator, 1-2 bytes, 3 clocks
// - 000110dw plus addressing byte is borrow subtract, 2 or 7 clocks
// - 0001110w is borrow subtract immediate from accumulator, 3 clocks
// - 100000sw reg 111 is compare immediate; 3 or 6 clocks
// - 0011110w is compare immediate with accumulator, 3 clocks
// - 00110111 is ASCII adjust after add, no operands, 3 clocks
// - 00100111 is decimal adjust after add, no operands, 3 clocks
// - 00111111 is ASCII adjust after subtract, 3 clocks
// - 00101111 is decimal adjust after subtract, no operands, 3 clocks
// - 1111011w reg 100 is unsigned product
// - Unsigned product takes 13, 21, 16 or 24 clocks
// - 1111011w reg 101 is signed product, 13/21 or 16/24 clocks
// - 011010s1 is signed immediate product, second byte if s=0, 21/24
// - 1111011w reg 110 is unsigned quotient, 14/22/17/25 clocks
module asd_decode
   import asd_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RSTN,
   input  wire logic        FETCH_VALID,
   input  wire logic [7:0]  FETCH_BYTE,
   output logic             FETCH_READY,
   output logic             OP_START,
   output asd_op_t          OP_KIND,
   output logic             OP_WORD,
   output logic             OP_DEST_REG,
   output logic             OP_MEM,
   output logic [1:0]       OP_MOD,
   output logic [2:0]       OP_REG,
   output logic [2:0]       OP_RM,
   output logic [15:0]      OP_IMM,
   output logic [CNT_W-1:0] OP_CLOCKS,
   output logic             OP_BUSY,
   output logic             OP_DONE,
   output logic             OP_ILLEGAL
);

   typedef enum logic [2:0] {ST_OPCODE, ST_MODRM, ST_IMM_LO, ST_IMM_HI, ST_EXEC} asd_st_t;

   typedef struct packed {
      asd_st_t          st;
      logic [7:0]       opc;
      logic [7:0]       modrm;
      asd_op_t          op;
      logic             word;
      logic             dest_reg;
      logic             imm2;
      logic             sx;
      logic [15:0]      imm;
      logic [CNT_W-1:0] clocks;
      logic             start;
      logic             illegal;
   } asd_dec_t;

   asd_dec_t         q;
   asd_dec_t         d;
   logic [1:0]       rst_sync_q;
   logic             rst_n;
   logic             take;
   logic             tmr_busy;
   logic             tmr_done;
   logic [1:0]       mod_f;
   logic [2:0]       reg_f;

   // ---------------------------------------------------------------------
   // Reset release through two flip-flops
   // ---------------------------------------------------------------------
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ---------------------------------------------------------------------
   // Clock count lookup
   // ---------------------------------------------------------------------
   function automatic logic [CNT_W-1:0] clocks_of(asd_op_t op, logic mem, logic word);
      logic [CNT_W-1:0] c;
      c = T_ADJUST;
      unique case (op)
         OP_MINUS_IMM_ACC:            c = T_SUBI_ACC;
         OP_MINUS_WITH_CARRY_IN_RM:   c = mem ? T_MWCI_MEM : T_MWCI_REG;
         OP_MINUS_WITH_CARRY_IN_ACC:  c = T_MWCI_ACC;
         OP_COMPARE_OP_RM:            c = mem ? T_CMPI_MEM : T_CMPI_REG;
         OP_COMPARE_OP_ACC:           c = T_CMPI_ACC;
         OP_PRODUCT_UNSIGNED:
            c = mem ? (word ? T_MULU_MW : T_MULU_MB) : (word ? T_MULU_RW : T_MULU_RB);
         OP_PRODUCT_SIGNED:
            c = mem ? (word ? T_MULS_MW : T_MULS_MB) : (word ? T_MULS_RW : T_MULS_RB);
         OP_PRODUCT_SIGNED_IMMEDIATE: c = mem ? T_MULI_MEM : T_MULI_REG;
         OP_QUOTIENT_UNSIGNED:
            c = mem ? (word ? T_DIVU_MW : T_DIVU_MB) : (word ? T_DIVU_RW : T_DIVU_RB);
         default:                     c = T_ADJUST;
      endcase
      return c;
   endfunction : clocks_of

   assign take  = FETCH_VALID && FETCH_READY;
   assign mod_f = FETCH_BYTE[MOD_POS +: 2];
   assign reg_f = FETCH_BYTE[REG_POS +: 3];

   // ---------------------------------------------------------------------
   // Byte sequencer: opcode, addressing byte, immediates, then execute
   // ---------------------------------------------------------------------
   always_comb begin
      d         = q;
      d.start   = 1'b0;
      d.illegal = 1'b0;
      unique case (q.st)
         ST_OPCODE: if (take) begin
            d.opc      = FETCH_BYTE;
            d.word     = FETCH_BYTE[0];
            d.dest_reg = 1'b0;
            d.sx       = 1'b0;
            d.imm      = '0;
            d.modrm    = {MOD_REG, 6'h00};
            d.imm2     = FETCH_BYTE[0];
            d.op       = OP_NONE;
            d.st       = ST_IMM_LO;
            if ((FETCH_BYTE & MASK_W) == OPC_SUBI_ACC) begin
               d.op = OP_MINUS_IMM_ACC;
            end else if ((FETCH_BYTE & MASK_W) == OPC_MWCI_ACC) begin
               d.op = OP_MINUS_WITH_CARRY_IN_ACC;
            end else if ((FETCH_BYTE & MASK_W) == OPC_CMPI_ACC) begin
               d.op = OP_COMPARE_OP_ACC;
            end else if ((FETCH_BYTE & MASK_DW) == OPC_MWCI_RM) begin
               d.op       = OP_MINUS_WITH_CARRY_IN_RM;
               d.dest_reg = FETCH_BYTE[1];
               d.st       = ST_MODRM;
            end else if ((FETCH_BYTE & MASK_DW) == OPC_GRP_IMM) begin
               // Only the word form with extend clear needs a high byte
               d.imm2 = (FETCH_BYTE[1:0] == 2'b01);
               d.sx   = (FETCH_BYTE[1:0] == 2'b11);
               d.st   = ST_MODRM;
            end else if ((FETCH_BYTE & MASK_W) == OPC_GRP_UNARY) begin
               d.st = ST_MODRM;
            end else if ((FETCH_BYTE & MASK_S) == OPC_MULI) begin
               d.op       = OP_PRODUCT_SIGNED_IMMEDIATE;
               d.dest_reg = 1'b1;
               d.imm2     = !FETCH_BYTE[1];
               d.sx       = FETCH_BYTE[1];
               d.st       = ST_MODRM;
            end else begin
               d.word = 1'b0;
               d.st   = ST_EXEC;
               unique case (FETCH_BYTE)
                  OPC_ASCII_ADD: d.op = OP_ASCII_ADD_FIX;
                  OPC_BCD_ADD:   d.op = OP_BCD_ADD_FIX;
                  OPC_ASCII_SUB: d.op = OP_ASCII_SUB_FIX;
                  OPC_BCD_SUB:   d.op = OP_BCD_SUB_FIX;
                  default:       d.op = OP_NONE;
               endcase
               if (d.op == OP_NONE) begin
                  // Foreign opcode: consumed and flagged, no timing started
                  d.illegal = 1'b1;
                  d.st      = ST_OPCODE;
               end else begin
                  d.clocks = clocks_of(d.op, 1'b0, 1'b0);
                  d.start  = 1'b1;
               end
            end
         end
         ST_MODRM: if (take) begin
            d.modrm = FETCH_BYTE;
            d.st    = ST_IMM_LO;
            if ((q.opc & MASK_DW) == OPC_GRP_IMM) begin
               d.op = (reg_f == REG_CMP) ? OP_COMPARE_OP_RM : OP_NONE;
            end else if ((q.opc & MASK_W) == OPC_GRP_UNARY) begin
               d.st = ST_EXEC;
               unique case (reg_f)
                  REG_MULU: d.op = OP_PRODUCT_UNSIGNED;
                  REG_MULS: d.op = OP_PRODUCT_SIGNED;
                  REG_DIVU: d.op = OP_QUOTIENT_UNSIGNED;
                  default:  d.op = OP_NONE;
               endcase
            end else if (q.op == OP_MINUS_WITH_CARRY_IN_RM) begin
               d.st = ST_EXEC;
            end
            if (d.op == OP_NONE) begin
               d.illegal = 1'b1;
               d.st      = ST_OPCODE;
            end else if (d.st == ST_EXEC) begin
               d.clocks = clocks_of(d.op, mod_f != MOD_REG, q.word);
               d.start  = 1'b1;
            end
         end
         ST_IMM_LO: if (take) begin
            d.imm[7:0]  = FETCH_BYTE;
            d.imm[15:8] = (q.sx && q.word) ? {8{FETCH_BYTE[7]}} : 8'h00;
            if (q.imm2) begin
               d.st = ST_IMM_HI;
            end else begin
               d.st     = ST_EXEC;
               d.clocks = clocks_of(q.op, q.modrm[MOD_POS +: 2] != MOD_REG, q.word);
               d.start  = 1'b1;
            end
         end
         ST_IMM_HI: if (take) begin
            d.imm[15:8] = FETCH_BYTE;
            d.st        = ST_EXEC;
            d.clocks    = clocks_of(q.op, q.modrm[MOD_POS +: 2] != MOD_REG, q.word);
            d.start     = 1'b1;
         end
         ST_EXEC: if (tmr_done) begin
            d.st = ST_OPCODE;
         end
      endcase
   end

   always_ff @(posedge CLOCK or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{st: ST_OPCODE, op: OP_NONE, default: '0};
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------------
   // Execution timing
   // ---------------------------------------------------------------------
   asd_cycle_timer #(.W(CNT_W)) u_timer (
      .clk   (CLOCK),
      .rst_n (rst_n),
      .start (q.start),
      .count (q.clocks),
      .busy  (tmr_busy),
      .done  (tmr_done)
   );

   // Outputs; ready drops during execution so the queue holds the next byte
   assign FETCH_READY = rst_n && (q.st != ST_EXEC) && !q.start;
   assign OP_START    = q.start;
   assign OP_KIND     = q.op;
   assign OP_WORD     = q.word;
   assign OP_DEST_REG = q.dest_reg;
   assign OP_MOD      = q.modrm[MOD_POS +: 2];
   assign OP_REG      = q.modrm[REG_POS +: 3];
   assign OP_RM       = q.modrm[RM_POS +: 3];
   assign OP_MEM      = (q.modrm[MOD_POS +: 2] != MOD_REG);
   assign OP_IMM      = q.imm;
   assign OP_CLOCKS   = q.clocks;
   assign OP_BUSY     = tmr_busy;
   assign OP_DONE     = tmr_done;
   assign OP_ILLEGAL  = q.illegal;

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!rst_n);

   sequence s_adjust_start;
      OP_START && (OP_KIND inside {OP_ASCII_ADD_FIX, OP_BCD_ADD_FIX,
                                   OP_ASCII_SUB_FIX, OP_BCD_SUB_FIX});
   endsequence
   sequence s_three_busy;
      OP_BUSY [*3] ##1 !OP_BUSY;
   endsequence

   a_subi_clocks: assert property (OP_START && OP_KIND == OP_MINUS_IMM_ACC |->
      OP_CLOCKS == T_SUBI_ACC) else $error("subtract imm acc clocks wrong");
   a_mwci_clocks: assert property (OP_START && OP_KIND == OP_MINUS_WITH_CARRY_IN_RM |->
      OP_CLOCKS == (OP_MEM ? T_MWCI_MEM : T_MWCI_REG)) else $error("borrow rm clocks wrong");
   a_mwci_acc: assert property (OP_START && OP_KIND == OP_MINUS_WITH_CARRY_IN_ACC |->
      OP_CLOCKS == T_MWCI_ACC && !OP_MEM) else $error("borrow acc clocks wrong");
   a_cmpi_rm: assert property (OP_START && OP_KIND == OP_COMPARE_OP_RM |->
      OP_REG == REG_CMP && OP_CLOCKS == (OP_MEM ? T_CMPI_MEM : T_CMPI_REG))
      else $error("compare rm decode wrong");
   a_cmpi_acc: assert property (OP_START && OP_KIND == OP_COMPARE_OP_ACC |->
      OP_CLOCKS == T_CMPI_ACC) else $error("compare acc clocks wrong");
   a_adjust_span: assert property (s_adjust_start |=> s_three_busy)
      else $error("adjust not busy three clocks");
   a_mulu_decode: assert property (OP_START && OP_KIND == OP_PRODUCT_UNSIGNED |->
      OP_REG == REG_MULU && OP_CLOCKS == (OP_MEM ? (OP_WORD ? T_MULU_MW : T_MULU_MB)
                                                 : (OP_WORD ? T_MULU_RW : T_MULU_RB)))
      else $error("unsigned product decode wrong");
   a_muls_decode: assert property (OP_START && OP_KIND == OP_PRODUCT_SIGNED |->
      OP_REG == REG_MULS && OP_CLOCKS == (OP_MEM ? (OP_WORD ? T_MULS_MW : T_MULS_MB)
                                                 : (OP_WORD ? T_MULS_RW : T_MULS_RB)))
      else $error("signed product decode wrong");
   a_muli_clocks: assert property (OP_START && OP_KIND == OP_PRODUCT_SIGNED_IMMEDIATE |->
      OP_DEST_REG && OP_CLOCKS == (OP_MEM ? T_MULI_MEM : T_MULI_REG))
      else $error("immediate product decode wrong");
   a_divu_decode: assert property (OP_START && OP_KIND == OP_QUOTIENT_UNSIGNED |->
      OP_REG == REG_DIVU && OP_CLOCKS == (OP_MEM ? (OP_WORD ? T_DIVU_MW : T_DIVU_MB)
                                                 : (OP_WORD ? T_DIVU_RW : T_DIVU_RB)))
      else $error("unsigned quotient decode wrong");
   a_byte_imm: assert property (OP_START && !OP_WORD && OP_KIND != OP_COMPARE_OP_RM |->
      OP_IMM[15:8] == 8'h00) else $error("byte operand has high immediate");
   a_dest_sel: assert property (OP_START && OP_KIND == OP_MINUS_WITH_CARRY_IN_RM |->
      OP_DEST_REG == q.opc[1]) else $error("destination select wrong");
   a_sign_ext: assert property (OP_START && q.sx && OP_WORD |->
      OP_IMM[15:8] == {8{OP_IMM[7]}}) else $error("immediate not sign extended");
   a_busy_len: assert property (OP_START |=> OP_BUSY ##0 (OP_BUSY throughout
      (##[0:24] OP_DONE))) else $error("busy window broken");

endmodule : asd_decode

// File: testbench/asd_fetch_model.sv
// Behavioural fetch queue that hands the decoder one byte per handshake.
// Assumes the decoder's ready is sampled at the rising edge with valid.
`timescale 1ns/10ps
module asd_fetch_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ready,
   input  wire logic       slow,
   output logic            valid = 1'b0,
   output logic [7:0]      data  = 8'h00
);
   // ----------------------------------------------------------------------
   // Byte queue
   // ----------------------------------------------------------------------
   logic [7:0] q[$];

   // Hold each byte until taken; idle data flips so a stale byte never looks fresh
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         valid <= 1'b0;
      end else if (!valid || ready) begin
         if (q.size() > 0 && !(slow && $urandom_range(1) == 1)) begin
            valid <= 1'b1;
            data  <= q.pop_front();
         end else begin
            valid <= 1'b0;
            data  <= ~data;
         end
      end
   end
endmodule : asd_fetch_model

// File: testbench/arith_subtract_multiply_decode_bench.sv
// Self-checking bench for the decoder, fed by the fetch queue model.
// Assumes the decoder's outputs settle well before the falling edge.
`timescale 1ns/10ps
module arith_subtract_multiply_decode_bench;
   import asd_pkg::*;
   logic CLOCK, RSTN, slow, fv, FETCH_READY, OP_START, OP_WORD, OP_DEST_REG, OP_MEM;
   logic OP_BUSY, OP_DONE, OP_ILLEGAL;
   logic [7:0] fb;
   logic [1:0] OP_MOD;
   logic [2:0] OP_REG, OP_RM;
   logic [15:0] OP_IMM;
   logic [4:0] OP_CLOCKS, lastc;
   asd_op_t OP_KIND;
   logic [27:0] exp_q[$];
   logic [27:0] tmp;
   logic [7:0] exp_m[$];
   logic [7:0] mtmp;
   logic [31:0] r;
   int errors = 0, checks = 0, bc = 0, cyc = 0;

   // ----------------------------------------------------------------------
   // Clock, design and fetch partner
   // ----------------------------------------------------------------------
   initial begin
      CLOCK = 1'b0;
      forever #20 CLOCK = ~CLOCK;
   end
   asd_decode i_asd_decode (.CLOCK(CLOCK), .RSTN(RSTN), .FETCH_VALID(fv), .FETCH_BYTE(fb),
      .FETCH_READY(FETCH_READY), .OP_START(OP_START), .OP_KIND(OP_KIND), .OP_WORD(OP_WORD),
      .OP_DEST_REG(OP_DEST_REG), .OP_MEM(OP_MEM), .OP_MOD(OP_MOD), .OP_REG(OP_REG),
      .OP_RM(OP_RM), .OP_IMM(OP_IMM), .OP_CLOCKS(OP_CLOCKS), .OP_BUSY(OP_BUSY),
      .OP_DONE(OP_DONE), .OP_ILLEGAL(OP_ILLEGAL));
   asd_fetch_model i_asd_fetch_model (.clk(CLOCK), .rst_n(RSTN), .ready(FETCH_READY),
      .slow(slow), .valid(fv), .data(fb));

   // ----------------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------------
   task automatic check(input logic [27:0] seen, input logic [27:0] expv);
      checks++;
      if (seen !== expv) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask : check

   // Queue the bytes of one instruction and note what decode must report
   task automatic run(input int n, input logic [31:0] b, input asd_op_t k, input logic w,
                      input logic d, input logic m, input logic [4:0] c, input logic [15:0] im);
      for (int i = 0; i < n; i++) i_asd_fetch_model.q.push_back(b[31-8*i -: 8]);
      exp_q.push_back({k, w, d, m, c, im});
      // Forms without an addressing byte report register mode and zero fields
      exp_m.push_back((k inside {OP_MINUS_WITH_CARRY_IN_RM, OP_COMPARE_OP_RM,
         OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_SIGNED_IMMEDIATE,
         OP_QUOTIENT_UNSIGNED}) ? b[23:16] : 8'hc0);
   endtask : run

   // Bounded wait until every queued instruction has finished executing
   task automatic drain(input string name);
      int t;
      t = 0;
      while ((exp_q.size() > 0 || OP_BUSY !== 1'b0 || OP_START !== 1'b0) && t < 4000) begin
         @(negedge CLOCK);
         t++;
      end
      // A stalled test counts against the verdict
      if (t >= 4000) errors++;
      $display("test %s done", name);
   endtask : drain

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // Output watcher: oldest note is matched against each completed decode
   always @(negedge CLOCK) begin
      if (OP_START === 1'b1) begin
         tmp = exp_q.pop_front();
         lastc = tmp[20:16];
         check({OP_KIND, OP_WORD, OP_DEST_REG, OP_MEM, OP_CLOCKS, OP_IMM}, tmp);
         mtmp = exp_m.pop_front();
         check({20'h0, OP_MOD, OP_REG, OP_RM}, {20'h0, mtmp});
      end
      if (OP_ILLEGAL === 1'b1) begin
         tmp = exp_q.pop_front();
         exp_m.delete(0);
         check({24'h0, OP_KIND}, {24'h0, tmp[27:24]});
      end
      // Fetch must be refused in the decode cycle and for the whole busy window
      if (OP_START === 1'b1 || OP_BUSY === 1'b1) check({27'h0, FETCH_READY}, 28'h0);
      if (OP_BUSY === 1'b1) bc++;
      if (OP_DONE === 1'b1) begin
         check(28'(bc), {23'h0, lastc});
         bc = 0;
      end
   end

   // Hang guard sized well above the longest test sequence
   always @(posedge CLOCK) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      RSTN = 1'b0;
      slow = 1'b0;
      void'($urandom(32'h91a1));
      repeat (3) @(posedge CLOCK);
      RSTN <= 1'b1;
      run(2, 32'h2c050000, OP_MINUS_IMM_ACC, 0, 0, 0, 5'h03, 16'h0005);
      run(3, 32'h2d341200, OP_MINUS_IMM_ACC, 1, 0, 0, 5'h03, 16'h1234);
      run(2, 32'h1bc10000, OP_MINUS_WITH_CARRY_IN_RM, 1, 1, 0, 5'h02, 16'h0);
      run(2, 32'h18060000, OP_MINUS_WITH_CARRY_IN_RM, 0, 0, 1, 5'h07, 16'h0);
      run(3, 32'h1d785600, OP_MINUS_WITH_CARRY_IN_ACC, 1, 0, 0, 5'h03, 16'h5678);
      run(3, 32'h83f88000, OP_COMPARE_OP_RM, 1, 0, 0, 5'h03, 16'hff80);
      run(4, 32'h8138cdab, OP_COMPARE_OP_RM, 1, 0, 1, 5'h06, 16'habcd);
      run(3, 32'h82f89000, OP_COMPARE_OP_RM, 0, 0, 0, 5'h03, 16'h0090);
      run(2, 32'h3c7f0000, OP_COMPARE_OP_ACC, 0, 0, 0, 5'h03, 16'h007f);
      run(4, 32'h69c13412, OP_PRODUCT_SIGNED_IMMEDIATE, 1, 1, 0, 5'h15, 16'h1234);
      run(3, 32'h6b01fe00, OP_PRODUCT_SIGNED_IMMEDIATE, 1, 1, 1, 5'h18, 16'hfffe);
      drain("operand forms");
      slow <= 1'b1;
      run(1, 32'h37000000, OP_ASCII_ADD_FIX, 0, 0, 0, 5'h03, 16'h0);
      run(1, 32'h27000000, OP_BCD_ADD_FIX, 0, 0, 0, 5'h03, 16'h0);
      run(1, 32'h3f000000, OP_ASCII_SUB_FIX, 0, 0, 0, 5'h03, 16'h0);
      run(1, 32'h2f000000, OP_BCD_SUB_FIX, 0, 0, 0, 5'h03, 16'h0);
      run(2, 32'hf6e10000, OP_PRODUCT_UNSIGNED, 0, 0, 0, 5'h0d, 16'h0);
      run(2, 32'hf7e10000, OP_PRODUCT_UNSIGNED, 1, 0, 0, 5'h15, 16'h0);
      run(2, 32'hf6210000, OP_PRODUCT_UNSIGNED, 0, 0, 1, 5'h10, 16'h0);
      run(2, 32'hf7210000, OP_PRODUCT_UNSIGNED, 1, 0, 1, 5'h18, 16'h0);
      run(2, 32'hf6e90000, OP_PRODUCT_SIGNED, 0, 0, 0, 5'h0d, 16'h0);
      run(2, 32'hf7290000, OP_PRODUCT_SIGNED, 1, 0, 1, 5'h18, 16'h0);
      run(2, 32'hf6f10000, OP_QUOTIENT_UNSIGNED, 0, 0, 0, 5'h0e, 16'h0);
      run(2, 32'hf7f10000, OP_QUOTIENT_UNSIGNED, 1, 0, 0, 5'h16, 16'h0);
      run(2, 32'hf6310000, OP_QUOTIENT_UNSIGNED, 0, 0, 1, 5'h11, 16'h0);
      run(2, 32'hf7310000, OP_QUOTIENT_UNSIGNED, 1, 0, 1, 5'h19, 16'h0);
      drain("adjust and product");
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         run(3, {8'h2d, r[7:0], r[15:8], 8'h0}, OP_MINUS_IMM_ACC, 1, 0, 0, 5'h03, r[15:0]);
         run(2, {8'h1c, r[23:16], 16'h0}, OP_MINUS_WITH_CARRY_IN_ACC, 0, 0, 0, 5'h03,
             {8'h0, r[23:16]});
      end
      drain("random immediates");
      run(1, 32'h90000000, OP_NONE, 0, 0, 0, 5'h0, 16'h0);
      run(2, 32'hf6d90000, OP_NONE, 0, 0, 0, 5'h0, 16'h0);
      run(2, 32'h80c00000, OP_NONE, 0, 0, 0, 5'h0, 16'h0);
      run(1, 32'h37000000, OP_ASCII_ADD_FIX, 0, 0, 0, 5'h03, 16'h0);
      drain("foreign opcodes");
      tally_and_finish();
   end
endmodule : arith_subtract_multiply_decode_bench
